// ==== hw/umiv_top.sv ====
// Interrupt aggregation, vector register and port interrupt of the microcontroller.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "umiv_defines.svh"
// Contract
// - Peripheral requests are ORed into the internal interrupt-0 line.
// - Fixed start addresses 0003h,000Bh,0013h,001Bh,0023h,002Bh, reset 0000h.
// - Enable register bits 0..5 enable internal_aggregate_irq,t0,port_level_irq,t1,serial,t2; reset 0.
// - Enable bit 7 is a global gate, reset 0.
// - Interrupt-0 is active low, level, held while any vector pends.
// - Eight-bit priority-encoded vector names up to 128 sources.
// - Vector bits 7..4 group, bits 3..1 source.
// - Vector bit 0 always reads 0.
// - Vector reads 00h when nothing pends.
// - Any vector write retires current vector and loads next pending.
// - Higher group wins; within a group first raised is served first; the code orders by an age that saturates at 31, then by lower index.
// - Group 4 (40h-46h) highest, group 1 (12h-16h) lowest.
// - Endpoint vectors 12h-16h, 22h-26h, 44h, 46h; others reserved.
// - Group 3 vectors 30h-3Ch, group 4 40h and 42h.
// - Eight active-low port-2 pins are ORed into interrupt-1.
// - Interrupt-1 is a level and also drives the wake-up request.
// - Source select 0 picks port-3 bit-3, 1 picks ORed port-2.
// - Interrupt-1 path has a delay set by a 4-bit field.
module umiv_top #(
  parameter int DELAY_STEP = `UMIV_DELAY_STEP
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire umiv_pkg::umiv_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [16:0] src_event,
  input wire umiv_pkg::umiv_std_irq_s std_irq,
  input wire logic [7:0] port2_pins,
  input wire logic port3_bit3_pin,
  output logic internal_aggregate_irq_n,
  output logic port_level_irq_n,
  output logic wakeup_req,
  output umiv_pkg::umiv_std_req_s std_req,
  output logic [15:0] start_address
);
  import umiv_pkg::*;

  // Source index to vector code, index 0 in the lowest group.
  localparam logic [7:0] VEC_CODE [0:16] = '{
    8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
    8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A, 8'h3C,
    8'h40, 8'h42, 8'h44, 8'h46
  };

  logic [7:0] standard_irq_enable_register;
  logic [7:0] interrupt_vector_register;
  logic port_irq_source_select;
  logic [3:0] port_irq_delay_config;
  logic [16:0] pending;
  logic [4:0] age [0:16];
  logic [7:0] next_vector;
  logic [4:0] cur_idx;
  logic cur_valid;
  logic [4:0] best_idx;
  logic best_found;
  logic [7:0] p2_s1, p2_s2, p2_s3;
  logic [2:0] p33_s;
  logic port_raw;
  logic port_stable;
  logic port_delayed;
  logic [7:0] dly_cnt;
  umiv_dly_e dly_state;
  logic wr_vec;

  assign wr_vec = bus.wr && (bus.addr == `UMIV_ADDR_VEC);

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      standard_irq_enable_register <= `UMIV_SIE_RESET;
    end else if (bus.wr && bus.addr == `UMIV_ADDR_SIE) begin
      standard_irq_enable_register <= bus.wdata & `UMIV_SIE_WMASK;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_irq_source_select <= 1'b0;
      port_irq_delay_config <= 4'h0;
    end else if (bus.wr) begin
      if (bus.addr == `UMIV_ADDR_MCFG) begin
        port_irq_source_select <= bus.wdata[`UMIV_BIT_XSEL];
      end
      if (bus.addr == `UMIV_ADDR_ICFG) begin
        port_irq_delay_config <= bus.wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pending sources with arrival order inside each group.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 17'h0_0000;
      for (int i = 0; i <= 16; i++) begin
        age[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i <= 16; i++) begin
        if (src_event[i] && !pending[i]) begin
          // A new arrival is the youngest; an event on a still-pending source is ignored, so a retire in the same cycle wins.
          pending[i] <= 1'b1;
          age[i] <= 5'h00;
        end else if (wr_vec && cur_valid && cur_idx == 5'(i)) begin
          pending[i] <= 1'b0;
        end else if (pending[i] && age[i] != 5'h1F) begin
          age[i] <= age[i] + 5'h01;
        end
      end
    end
  end

  // Highest group first; within a group the highest age, saturating at 31, with the lower index winning a tie.
  // The source being retired in this cycle is left out so that it does not show again in the next cycle.
  always_comb begin
    best_idx = 5'h00;
    best_found = 1'b0;
    for (int i = 0; i <= 16; i++) begin
      if (pending[i] && !(wr_vec && cur_valid && cur_idx == 5'(i))) begin
        if (!best_found || VEC_CODE[i][7:4] > VEC_CODE[best_idx][7:4] ||
            (VEC_CODE[i][7:4] == VEC_CODE[best_idx][7:4] && age[i] > age[best_idx])) begin
          best_idx = 5'(i);
          best_found = 1'b1;
        end
      end
    end
    next_vector = best_found ? {VEC_CODE[best_idx][7:1], 1'b0} : `UMIV_VEC_NONE;
  end

  // The presented vector follows the best pending source, so a higher group that
  // arrives later takes over; a write retires whatever is presented.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_vector_register <= `UMIV_VEC_NONE;
      cur_idx <= 5'h00;
      cur_valid <= 1'b0;
    end else begin
      interrupt_vector_register <= next_vector;
      cur_idx <= best_idx;
      cur_valid <= best_found;
    end
  end

  // Active-low level while anything pends; the enables gate only the core request.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      internal_aggregate_irq_n <= 1'b1;
    end else begin
      internal_aggregate_irq_n <= !(|pending);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port interrupt: synchroniser, source select and delay.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      p2_s1 <= 8'hFF;
      p2_s2 <= 8'hFF;
      p2_s3 <= 8'hFF;
      p33_s <= 3'b111;
    end else begin
      p2_s1 <= port2_pins;
      p2_s2 <= p2_s1;
      p2_s3 <= p2_s2;
      p33_s <= {p33_s[1:0], port3_bit3_pin};
    end
  end

  always_comb begin
    if (port_irq_source_select) begin
      port_raw = (|(~p2_s2)) && (p2_s2 == p2_s3);
    end else begin
      port_raw = !p33_s[1] && (p33_s[1] == p33_s[2]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_stable <= 1'b0;
    end else if (port_irq_source_select ? (p2_s2 == p2_s3) : (p33_s[1] == p33_s[2])) begin
      port_stable <= port_raw;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dly_state <= UMIV_DLY_IDLE;
      dly_cnt <= 8'h00;
      port_delayed <= 1'b0;
    end else if (!port_stable) begin
      dly_state <= UMIV_DLY_IDLE;
      port_delayed <= 1'b0;
    end else begin
      unique case (dly_state)
        UMIV_DLY_IDLE: begin
          if (!port_delayed) begin
            dly_state <= UMIV_DLY_COUNT;
            dly_cnt <= 8'(port_irq_delay_config * DELAY_STEP);
          end
        end
        UMIV_DLY_COUNT: begin
          if (dly_cnt == 8'h00) begin
            port_delayed <= 1'b1;
            dly_state <= UMIV_DLY_IDLE;
          end else begin
            dly_cnt <= dly_cnt - 8'h01;
          end
        end
      endcase
    end
  end

  assign port_level_irq_n = !port_delayed;
  assign wakeup_req = port_delayed;

  ////////////////////////////////////////////////////////////////////////////////
  // Gated requests to the core and start address of the winner.

  always_comb begin
    logic ea;
    ea = standard_irq_enable_register[`UMIV_BIT_EA];
    std_req.internal_aggregate_irq = ea && standard_irq_enable_register[`UMIV_BIT_INTERNAL_AGGREGATE_IRQ] &&
                   !internal_aggregate_irq_n;
    std_req.timer0 = ea && standard_irq_enable_register[`UMIV_BIT_ET0] && std_irq.timer0;
    std_req.port_level_irq = ea && standard_irq_enable_register[`UMIV_BIT_EX1] && port_delayed;
    std_req.timer1 = ea && standard_irq_enable_register[`UMIV_BIT_ET1] && std_irq.timer1;
    std_req.serial = ea && standard_irq_enable_register[`UMIV_BIT_ES] && std_irq.serial;
    std_req.timer2 = ea && standard_irq_enable_register[`UMIV_BIT_ET2] && std_irq.timer2;
    if (std_req.internal_aggregate_irq) begin
      start_address = `UMIV_START_INTERNAL_AGGREGATE_IRQ;
    end else if (std_req.timer0) begin
      start_address = `UMIV_START_T0;
    end else if (std_req.port_level_irq) begin
      start_address = `UMIV_START_PORT_LEVEL_IRQ;
    end else if (std_req.timer1) begin
      start_address = `UMIV_START_T1;
    end else if (std_req.serial) begin
      start_address = `UMIV_START_SER;
    end else if (std_req.timer2) begin
      start_address = `UMIV_START_T2;
    end else begin
      start_address = `UMIV_START_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, unmapped reads give zero.

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `UMIV_ADDR_SIE: rdata <= standard_irq_enable_register;
        `UMIV_ADDR_VEC: rdata <= interrupt_vector_register;
        `UMIV_ADDR_MCFG: rdata <= {7'h00, port_irq_source_select};
        `UMIV_ADDR_ICFG: rdata <= {4'h0, port_irq_delay_config};
        `UMIV_ADDR_PEND: rdata <= {internal_aggregate_irq_n, port_delayed, 6'h00};
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule // umiv_top
`default_nettype wire

// ==== hw/umiv_defines.svh ====
// Register offsets, field positions, reset values and timing constants of the vectoring block.
`ifndef UMIV_DEFINES_SVH
`define UMIV_DEFINES_SVH
`define UMIV_ADDR_SIE 4'h0
`define UMIV_ADDR_VEC 4'h1
`define UMIV_ADDR_MCFG 4'h2
`define UMIV_ADDR_ICFG 4'h3
`define UMIV_ADDR_PEND 4'h4
`define UMIV_SIE_RESET 8'h00
`define UMIV_SIE_WMASK 8'hBF
`define UMIV_BIT_INTERNAL_AGGREGATE_IRQ 0
`define UMIV_BIT_ET0 1
`define UMIV_BIT_EX1 2
`define UMIV_BIT_ET1 3
`define UMIV_BIT_ES 4
`define UMIV_BIT_ET2 5
`define UMIV_BIT_EA 7
`define UMIV_BIT_XSEL 0
`define UMIV_VEC_NONE 8'h00
`define UMIV_START_RESET 16'h0000
`define UMIV_START_INTERNAL_AGGREGATE_IRQ 16'h0003
`define UMIV_START_T0 16'h000B
`define UMIV_START_PORT_LEVEL_IRQ 16'h0013
`define UMIV_START_T1 16'h001B
`define UMIV_START_SER 16'h0023
`define UMIV_START_T2 16'h002B
`define UMIV_DELAY_STEP 4
`define UMIV_NSRC 17
`endif

// ==== hw/umiv_pkg.sv ====
// Types shared by the interrupt vectoring block.
package umiv_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umiv_bus_s;
  typedef struct packed {
    logic timer0;
    logic timer1;
    logic timer2;
    logic serial;
  } umiv_std_irq_s;
  typedef struct packed {
    logic internal_aggregate_irq;
    logic timer0;
    logic port_level_irq;
    logic timer1;
    logic serial;
    logic timer2;
  } umiv_std_req_s;
  typedef enum logic [0:0] {
    UMIV_DLY_IDLE = 1'b0,
    UMIV_DLY_COUNT = 1'b1
  } umiv_dly_e;
endpackage

// ==== testbench/umiv_props.sv ====
// Concurrent checks on the ports of the interrupt vectoring block.
`timescale 1ns/100ps
`default_nettype none
`include "umiv_defines.svh"
module umiv_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire umiv_pkg::umiv_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic [16:0] src_event,
  input wire umiv_pkg::umiv_std_irq_s std_irq,
  input wire logic internal_aggregate_irq_n,
  input wire logic port_level_irq_n,
  input wire logic wakeup_req,
  input wire umiv_pkg::umiv_std_req_s std_req,
  input wire logic [15:0] start_address
);
  import umiv_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence vec_rd;
    bus.rd && bus.addr == `UMIV_ADDR_VEC;
  endsequence
  sequence irq_soon;
    ##[1:3] !internal_aggregate_irq_n;
  endsequence
  chk_vec_even: assert property (vec_rd |=> !rdata[0]) else $error("vector odd");
  chk_vec_group: assert property (vec_rd |=> rdata[7:4] <= 4'h4) else $error("bad group");
  chk_vec_idle: assert property (vec_rd ##0 (internal_aggregate_irq_n
    && $past(internal_aggregate_irq_n)) |=> rdata == `UMIV_VEC_NONE) else $error("vec not 00");
  chk_gap_bit: assert property (bus.rd && bus.addr == `UMIV_ADDR_SIE |=> !rdata[6])
    else $error("enable bit 6 set");
  chk_irq_level: assert property ($rose(src_event[16]) |-> irq_soon) else $error("no irq");
  chk_internal_aggregate_irq_cause: assert property (std_req.internal_aggregate_irq |-> !internal_aggregate_irq_n
    && start_address == `UMIV_START_INTERNAL_AGGREGATE_IRQ) else $error("internal_aggregate_irq request wrong");
  chk_timer_cause: assert property (std_req.timer0 |-> std_irq.timer0) else $error("t0 req");
  chk_wake_link: assert property (std_req.port_level_irq |-> !port_level_irq_n && wakeup_req)
    else $error("wake");
  chk_start_idle: assert property (std_req == '0 |-> start_address == `UMIV_START_RESET)
    else $error("start not 0000");
endmodule // umiv_props
bind umiv_top umiv_props chk_u (.ref_clk, .nrst, .bus, .rdata, .src_event, .std_irq,
  .internal_aggregate_irq_n, .port_level_irq_n, .wakeup_req, .std_req, .start_address);
`default_nettype wire

// ==== testbench/umiv_mcu_model.sv ====
// Microcontroller side: register bus master and firmware acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "umiv_defines.svh"
module umiv_mcu_model (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output umiv_pkg::umiv_bus_s bus
);
  import umiv_pkg::*;
  initial bus = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(posedge ref_clk);
    d = rdata;
  endtask
  // Firmware reads the vector and writes it back to retire it.
  task automatic service(output logic [7:0] v);
    rd(`UMIV_ADDR_VEC, v);
    wr(`UMIV_ADDR_VEC, v);
  endtask
endmodule // umiv_mcu_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the interrupt vectoring block.
`timescale 1ns/100ps
`default_nettype none
`include "umiv_defines.svh"
module testbench;
  import umiv_pkg::*;
  localparam int STEP = 4;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  umiv_bus_s bus;
  logic [7:0] rdata;
  logic [16:0] src_event = '0;
  umiv_std_irq_s std_irq = '0;
  logic [7:0] port2_pins = 8'hFF;
  logic port3_bit3_pin = 1'b1;
  logic internal_aggregate_irq_n, port_level_irq_n, wakeup_req;
  umiv_std_req_s std_req;
  logic [15:0] start_address;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] v;
  int n0, n3;
  always #25 ref_clk = ~ref_clk;
  umiv_top #(.DELAY_STEP(STEP)) dut_u (.ref_clk, .nrst, .bus, .rdata, .src_event, .std_irq,
    .port2_pins, .port3_bit3_pin, .internal_aggregate_irq_n, .port_level_irq_n, .wakeup_req,
    .std_req, .start_address);
  umiv_mcu_model mcu_u (.ref_clk, .rdata, .bus);
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_enable();
    logic [7:0] ens [4] = '{8'h82, 8'h88, 8'h90, 8'hA0};
    logic [15:0] adr [4] = '{`UMIV_START_T0, `UMIV_START_T1, `UMIV_START_SER, `UMIV_START_T2};
    mcu_u.rd(`UMIV_ADDR_SIE, v);
    chk("enable reset", 16'h0000, v);
    mcu_u.wr(`UMIV_ADDR_SIE, 8'hFF);
    mcu_u.rd(`UMIV_ADDR_SIE, v);
    chk("enable bit6", 16'h00BF, v);
    mcu_u.rd(4'hF, v);
    chk("unmapped", 16'h0000, v);
    std_irq <= '1;
    mcu_u.wr(`UMIV_ADDR_SIE, 8'h3F);
    chk("gate off", 16'h0000, std_req);
    for (int i = 0; i < 4; i++) begin
      mcu_u.wr(`UMIV_ADDR_SIE, ens[i]);
      chk("start", adr[i], start_address);
    end
    std_irq <= '0;
  endtask
  task automatic t_codes();
    logic [7:0] codes [17] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h34,
      8'h36, 8'h38, 8'h3A, 8'h3C, 8'h40, 8'h42, 8'h44, 8'h46};
    for (int i = 0; i < 17; i++) begin
      src_event[i] <= 1'b1;
      @(posedge ref_clk);
      src_event[i] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("irq low", 16'h0000, internal_aggregate_irq_n);
      mcu_u.service(v);
      chk("vector", codes[i], v);
    end
    repeat (2) @(posedge ref_clk);
    chk("irq idle", 16'h0001, internal_aggregate_irq_n);
    mcu_u.rd(`UMIV_ADDR_VEC, v);
    chk("vector none", 16'h0000, v);
  endtask
  task automatic t_order();
    mcu_u.wr(`UMIV_ADDR_SIE, 8'h81);
    src_event[1] <= 1'b1;
    @(posedge ref_clk);
    src_event <= 17'h10001;
    @(posedge ref_clk);
    src_event <= '0;
    repeat (3) @(posedge ref_clk);
    chk("internal_aggregate_irq start", `UMIV_START_INTERNAL_AGGREGATE_IRQ, start_address);
    mcu_u.service(v);
    chk("highest", 16'h0046, v);
    mcu_u.service(v);
    chk("first come", 16'h0014, v);
    mcu_u.service(v);
    chk("lowest", 16'h0012, v);
    mcu_u.wr(`UMIV_ADDR_SIE, 8'h84);
  endtask
  task automatic measure(input logic [7:0] dly, output int n);
    mcu_u.wr(`UMIV_ADDR_ICFG, dly);
    port2_pins <= 8'hDF;
    n = 0;
    while (port_level_irq_n !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("wake", 16'h0001, wakeup_req);
    chk("port_level_irq start", `UMIV_START_PORT_LEVEL_IRQ, start_address);
    port2_pins <= 8'hFF;
    repeat (20) @(posedge ref_clk);
    chk("released", 16'h0001, port_level_irq_n);
  endtask
  task automatic t_port();
    port2_pins <= 8'h00;
    repeat (30) @(posedge ref_clk);
    chk("p2 unselected", 16'h0001, port_level_irq_n);
    port2_pins <= 8'hFF;
    port3_bit3_pin <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk("p3 selected", 16'h0000, port_level_irq_n);
    port3_bit3_pin <= 1'b1;
    mcu_u.wr(`UMIV_ADDR_MCFG, 8'h01);
    repeat (20) @(posedge ref_clk);
    measure(8'h00, n0);
    measure(8'h03, n3);
    chk("delay", 16'(3 * STEP), 16'(n3 - n0));
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_enable();
    t_codes();
    t_order();
    t_port();
    conclude();
  end
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
